// ---- common/nvj_params.svh ----
// Constants of the nonvolatile job controller
`ifndef NVJ_PARAMS_SVH
`define NVJ_PARAMS_SVH
// ----------------------------------------
// Job codes and acknowledgements
// ----------------------------------------
`define NVJ_CODE_IDLE 8'h00
`define NVJ_CODE_BACKUP 8'h01
`define NVJ_CODE_RESTORE 8'h02
`define NVJ_CODE_DELETE 8'h03
`define NVJ_ACK_OK 8'hFF
`define NVJ_REJ_STATE 8'h11
`define NVJ_REJ_VALUE 8'h14
`define NVJ_REJ_PULSE 8'h6B
`define NVJ_REJ_BLOCKED 8'h84
`define NVJ_REJ_WRITE 8'hCC
// ----------------------------------------
// Execution error codes and parameter reset value
// ----------------------------------------
`define NVJ_ERR_DELETE 8'h0A
`define NVJ_ERR_BK_NOCARD 8'h0B
`define NVJ_ERR_BK_FULL 8'h0C
`define NVJ_ERR_BK_INCOMPL 8'h0D
`define NVJ_ERR_RS_NOCARD 8'h0E
`define NVJ_ERR_RS_CHKSUM 8'h0F
`define NVJ_ERR_RS_NONE 8'h10
`define NVJ_PARAM_RESET 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define NVJ_CLK_PERIOD_NS 10
`define NVJ_ACK_DELAY_NS 1000
`define NVJ_ACK_CYCLES \
  ((`NVJ_ACK_DELAY_NS + `NVJ_CLK_PERIOD_NS - 1) / `NVJ_CLK_PERIOD_NS)
`define NVJ_BOOT_CYCLES 3
`endif

// ---- common/nvj_pkg.sv ----
// Types of the nonvolatile job controller
package nvj_pkg;
  typedef enum logic [2:0] {
    ST_BOOT, ST_IDLE, ST_ACK, ST_ISSUE, ST_WAIT
  } nvj_state_t;
  typedef enum logic [2:0] {
    JOB_NONE, JOB_BACKUP, JOB_RESTORE, JOB_DELETE, JOB_AUTO
  } nvj_job_t;
  typedef enum logic [2:0] {
    MC_NONE, MC_RENAME, MC_WRITE, MC_CHK_PRI, MC_CHK_FB, MC_CLEAR,
    MC_LOAD_PRI, MC_LOAD_FB
  } nvj_cmd_t;
  typedef struct packed {
    logic valid;
    logic from_cyclic_master;
    logic [7:0] value;
  } nvj_wr_req_t;
  typedef struct packed {
    logic done;
    logic ok;
    logic absent;
  } nvj_mem_rsp_t;
endpackage : nvj_pkg

// ---- src/nvj_job_ctrl.sv ----
// Backup, restore and delete job control for the nonvolatile RAM
`timescale 1ns/100ps
`include "nvj_params.svh"
module nvj_job_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Job parameter access
  input wire nvj_pkg::nvj_wr_req_t i_wr,
  output logic o_wr_ack,
  output logic [7:0] o_wr_code,
  output logic [7:0] o_nvram_job_parameter,
  output logic o_busy,
  // Protection and drive status
  input wire logic i_write_protect_enable,
  input wire logic i_param_change_blocked,
  input wire logic i_pulse_enable_any,
  input wire logic i_card_present,
  input wire logic i_card_full,
  input wire logic i_control_unit_replaced,
  // Memory engine
  output logic o_mem_req,
  output nvj_pkg::nvj_cmd_t o_mem_cmd,
  input wire nvj_pkg::nvj_mem_rsp_t i_mem_rsp,
  output logic o_warm_restart
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] async_in;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  assign async_in = {i_control_unit_replaced, i_card_full,
                     i_card_present, i_pulse_enable_any};
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
        begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end
        else
        begin
          sync_a[g] <= async_in[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate
  logic s_pulse;
  logic s_card;
  logic s_full;
  logic s_replaced;
  assign s_pulse = sync_b[0];
  assign s_card = sync_b[1];
  assign s_full = sync_b[2];
  assign s_replaced = sync_b[3];

  // ----------------------------------------
  // Write check
  // ----------------------------------------
  function automatic logic [7:0] f_check(input logic [7:0] value,
    input logic cyc, input logic wp, input logic busy,
    input logic blocked, input logic pulse);
    logic [7:0] code;
    code = `NVJ_ACK_OK;
    if (wp && !cyc)
      code = `NVJ_REJ_WRITE;
    else if (busy)
      code = `NVJ_REJ_STATE;
    else if (value > `NVJ_CODE_DELETE)
      code = `NVJ_REJ_VALUE;
    else if (blocked)
      code = `NVJ_REJ_BLOCKED;
    else if (pulse && (value == `NVJ_CODE_RESTORE ||
                       value == `NVJ_CODE_DELETE))
      code = `NVJ_REJ_PULSE;
    return code;
  endfunction : f_check

  function automatic nvj_pkg::nvj_cmd_t f_load(input logic fb);
    return fb ? nvj_pkg::MC_LOAD_FB : nvj_pkg::MC_LOAD_PRI;
  endfunction : f_load

  // ----------------------------------------
  // Job sequencer
  // ----------------------------------------
  nvj_pkg::nvj_state_t state, next_state;
  nvj_pkg::nvj_job_t job, next_job;
  nvj_pkg::nvj_cmd_t cmd, next_cmd;
  logic [7:0] cnt, next_cnt;
  logic [7:0] param, next_param;
  logic [7:0] wr_code, next_wr_code;
  logic wr_ack, next_wr_ack;
  logic mem_req, next_mem_req;
  logic restart, next_restart;
  logic src_fb, next_src_fb;
  logic pri_absent, next_pri_absent;
  logic [7:0] chk;

  always_comb
  begin
    next_state = state;
    next_job = job;
    next_cmd = cmd;
    next_cnt = cnt;
    next_param = param;
    next_wr_code = wr_code;
    next_wr_ack = 1'b0;
    next_mem_req = 1'b0;
    next_restart = 1'b0;
    next_src_fb = src_fb;
    next_pri_absent = pri_absent;
    chk = f_check(i_wr.value, i_wr.from_cyclic_master,
                  i_write_protect_enable, state != nvj_pkg::ST_IDLE,
                  i_param_change_blocked, s_pulse);
    if (i_wr.valid)
    begin
      next_wr_ack = 1'b1;
      next_wr_code = chk;
      if (chk == `NVJ_ACK_OK)
      begin
        next_param = i_wr.value;
        if (i_wr.value != `NVJ_CODE_IDLE)
        begin
          next_cnt = 8'h00;
          next_state = nvj_pkg::ST_ACK;
          next_job = nvj_pkg::nvj_job_t'(i_wr.value[2:0]);
        end
      end
    end
    case (state)
      nvj_pkg::ST_BOOT:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(`NVJ_BOOT_CYCLES - 1))
        begin
          next_cnt = 8'h00;
          next_state = nvj_pkg::ST_IDLE;
          if (s_replaced)
          begin
            next_job = nvj_pkg::JOB_AUTO;
            next_cmd = nvj_pkg::MC_CLEAR;
            next_state = nvj_pkg::ST_ISSUE;
          end
        end
      end
      nvj_pkg::ST_IDLE:
        next_cnt = 8'h00;
      nvj_pkg::ST_ACK:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(`NVJ_ACK_CYCLES - 1))
        begin
          next_param = `NVJ_ACK_OK;
          next_state = nvj_pkg::ST_ISSUE;
          case (job)
            nvj_pkg::JOB_BACKUP:
            begin
              next_cmd = nvj_pkg::MC_RENAME;
              if (!s_card)
                next_param = `NVJ_ERR_BK_NOCARD;
              else if (s_full)
                next_param = `NVJ_ERR_BK_FULL;
            end
            nvj_pkg::JOB_RESTORE:
            begin
              next_cmd = nvj_pkg::MC_CHK_PRI;
              if (!s_card)
                next_param = `NVJ_ERR_RS_NOCARD;
            end
            default:
            begin
              next_restart = 1'b1;
              next_cmd = nvj_pkg::MC_CLEAR;
            end
          endcase
          if (job != nvj_pkg::JOB_DELETE && (!s_card ||
              (job == nvj_pkg::JOB_BACKUP && s_full)))
          begin
            next_state = nvj_pkg::ST_IDLE;
            next_job = nvj_pkg::JOB_NONE;
          end
        end
      end
      nvj_pkg::ST_ISSUE:
      begin
        next_mem_req = 1'b1;
        next_state = nvj_pkg::ST_WAIT;
      end
      nvj_pkg::ST_WAIT:
      begin
        if (i_mem_rsp.done)
        begin
          next_state = nvj_pkg::ST_IDLE;
          case (cmd)
            nvj_pkg::MC_RENAME:
            begin
              next_cmd = nvj_pkg::MC_WRITE;
              next_state = nvj_pkg::ST_ISSUE;
            end
            nvj_pkg::MC_WRITE:
              next_param = i_mem_rsp.ok ? `NVJ_PARAM_RESET
                                        : `NVJ_ERR_BK_INCOMPL;
            nvj_pkg::MC_CHK_PRI, nvj_pkg::MC_CHK_FB:
            begin
              next_state = nvj_pkg::ST_ISSUE;
              if (i_mem_rsp.ok)
              begin
                next_src_fb = cmd == nvj_pkg::MC_CHK_FB;
                if (job == nvj_pkg::JOB_AUTO)
                  next_cmd = f_load(cmd == nvj_pkg::MC_CHK_FB);
                else
                begin
                  next_restart = 1'b1;
                  next_cmd = nvj_pkg::MC_CLEAR;
                end
              end
              else if (cmd == nvj_pkg::MC_CHK_PRI)
              begin
                next_pri_absent = i_mem_rsp.absent;
                next_cmd = nvj_pkg::MC_CHK_FB;
              end
              else
              begin
                next_state = nvj_pkg::ST_IDLE;
                if (job != nvj_pkg::JOB_AUTO)
                  next_param = (pri_absent && i_mem_rsp.absent)
                    ? `NVJ_ERR_RS_NONE : `NVJ_ERR_RS_CHKSUM;
              end
            end
            nvj_pkg::MC_CLEAR:
            begin
              if (job == nvj_pkg::JOB_DELETE)
                next_param = i_mem_rsp.ok ? `NVJ_PARAM_RESET
                                          : `NVJ_ERR_DELETE;
              else
              begin
                next_state = nvj_pkg::ST_ISSUE;
                next_cmd = (job == nvj_pkg::JOB_AUTO)
                  ? nvj_pkg::MC_CHK_PRI : f_load(src_fb);
              end
            end
            default:
              if (job == nvj_pkg::JOB_RESTORE)
                next_param = i_mem_rsp.ok ? `NVJ_PARAM_RESET
                                          : `NVJ_ERR_RS_CHKSUM;
          endcase
          if (next_state == nvj_pkg::ST_IDLE)
            next_job = nvj_pkg::JOB_NONE;
        end
      end
      default:
        next_state = nvj_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state <= nvj_pkg::ST_BOOT;
      job <= nvj_pkg::JOB_NONE;
      cmd <= nvj_pkg::MC_NONE;
      cnt <= 8'h00;
      param <= `NVJ_PARAM_RESET;
      wr_code <= 8'h00;
      wr_ack <= 1'b0;
      mem_req <= 1'b0;
      restart <= 1'b0;
      src_fb <= 1'b0;
      pri_absent <= 1'b0;
    end
    else
    begin
      state <= next_state;
      job <= next_job;
      cmd <= next_cmd;
      cnt <= next_cnt;
      param <= next_param;
      wr_code <= next_wr_code;
      wr_ack <= next_wr_ack;
      mem_req <= next_mem_req;
      restart <= next_restart;
      src_fb <= next_src_fb;
      pri_absent <= next_pri_absent;
    end
  end

  logic busy_q;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      busy_q <= 1'b1;
    else
      busy_q <= next_state != nvj_pkg::ST_IDLE;
  end

  assign o_nvram_job_parameter = param;
  assign o_wr_ack = wr_ack;
  assign o_wr_code = wr_code;
  assign o_mem_req = mem_req;
  assign o_mem_cmd = cmd;
  assign o_warm_restart = restart;
  assign o_busy = busy_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  localparam int ACK_DLY = `NVJ_ACK_CYCLES + 1;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic wr_open;
  assign wr_open = i_wr.valid && state == nvj_pkg::ST_IDLE &&
    !(i_write_protect_enable && !i_wr.from_cyclic_master) &&
    !i_param_change_blocked;

  property p_rename_first;
    state == nvj_pkg::ST_WAIT && cmd == nvj_pkg::MC_RENAME &&
      i_mem_rsp.done |-> ##2 (o_mem_req && o_mem_cmd == nvj_pkg::MC_WRITE);
  endproperty
  a_rename_first: assert property (p_rename_first)
    else $error("write did not follow rename");
  property p_backup_pulse;
    wr_open && i_wr.value == `NVJ_CODE_BACKUP && s_pulse
      |=> o_wr_ack && o_wr_code == `NVJ_ACK_OK && !o_warm_restart;
  endproperty
  a_backup_pulse: assert property (p_backup_pulse)
    else $error("backup refused under pulse enable");
  property p_restore_pulse;
    wr_open && i_wr.value == `NVJ_CODE_RESTORE && s_pulse
      |=> o_wr_ack && o_wr_code == `NVJ_REJ_PULSE;
  endproperty
  a_restore_pulse: assert property (p_restore_pulse)
    else $error("restore not refused under pulse enable");
  property p_delete_pulse;
    wr_open && i_wr.value == `NVJ_CODE_DELETE && s_pulse
      |=> o_wr_code == `NVJ_REJ_PULSE && $stable(o_nvram_job_parameter);
  endproperty
  a_delete_pulse: assert property (p_delete_pulse)
    else $error("delete not refused under pulse enable");
  property p_ack_delay;
    wr_open && i_wr.value == `NVJ_CODE_DELETE && !s_pulse
      |-> ##ACK_DLY (o_nvram_job_parameter == `NVJ_ACK_OK &&
                     o_warm_restart);
  endproperty
  a_ack_delay: assert property (p_ack_delay)
    else $error("delete not acknowledged on time");
  property p_protect;
    i_wr.valid && i_write_protect_enable && !i_wr.from_cyclic_master
      |=> o_wr_ack && o_wr_code == `NVJ_REJ_WRITE;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected write not rejected");
  property p_busy;
    i_wr.valid && state != nvj_pkg::ST_IDLE &&
      !(i_write_protect_enable && !i_wr.from_cyclic_master)
      |=> o_wr_code == `NVJ_REJ_STATE;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write during job not rejected");
  property p_backup_end;
    state == nvj_pkg::ST_WAIT && cmd == nvj_pkg::MC_WRITE && i_mem_rsp.done
      |=> o_nvram_job_parameter == ($past(i_mem_rsp.ok) ? `NVJ_PARAM_RESET
                                                       : `NVJ_ERR_BK_INCOMPL);
  endproperty
  a_backup_end: assert property (p_backup_end)
    else $error("backup end code wrong");
  c_backup: cover property (state == nvj_pkg::ST_WAIT &&
    cmd == nvj_pkg::MC_WRITE && i_mem_rsp.done && i_mem_rsp.ok);
  c_restore_fb: cover property (o_mem_req &&
    o_mem_cmd == nvj_pkg::MC_LOAD_FB);
  c_auto: cover property (job == nvj_pkg::JOB_AUTO && o_mem_req);
endmodule : nvj_job_ctrl

// ---- verification/nvj_job_ctrl_bench.sv ----
// Self-checking bench of the nonvolatile job controller
`timescale 1ns/100ps
`include "nvj_params.svh"
module nvj_job_ctrl_bench;
  localparam logic [2:0] RN = nvj_pkg::MC_RENAME;
  localparam logic [2:0] WR = nvj_pkg::MC_WRITE;
  localparam logic [2:0] CP = nvj_pkg::MC_CHK_PRI;
  localparam logic [2:0] CF = nvj_pkg::MC_CHK_FB;
  localparam logic [2:0] CL = nvj_pkg::MC_CLEAR;
  localparam logic [2:0] LP = nvj_pkg::MC_LOAD_PRI;
  localparam logic [2:0] LF = nvj_pkg::MC_LOAD_FB;
  localparam logic [7:0] ACK = `NVJ_ACK_OK;
  localparam logic [7:0] Z = `NVJ_PARAM_RESET;
  localparam logic [7:0] BK = `NVJ_CODE_BACKUP;
  localparam logic [7:0] RS = `NVJ_CODE_RESTORE;
  localparam logic [7:0] DL = `NVJ_CODE_DELETE;
  logic i_clk;
  logic i_sys_rst;
  nvj_pkg::nvj_wr_req_t i_wr;
  logic [7:0] code;
  logic [7:0] param;
  logic ack, busy, wp, blk, pulse, card, full, repl, req, wrst, slow, op_ok;
  logic [3:0] files;
  nvj_pkg::nvj_cmd_t cmd;
  nvj_pkg::nvj_mem_rsp_t rsp;
  nvj_pkg::nvj_cmd_t cmds[$];
  int restarts;
  int num_errors;
  int comparisons;
  nvj_job_ctrl i_dut (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(i_wr),
    .o_wr_ack(ack),
    .o_wr_code(code),
    .o_nvram_job_parameter(param),
    .o_busy(busy),
    .i_write_protect_enable(wp),
    .i_param_change_blocked(blk),
    .i_pulse_enable_any(pulse),
    .i_card_present(card),
    .i_card_full(full),
    .i_control_unit_replaced(repl),
    .o_mem_req(req),
    .o_mem_cmd(cmd),
    .i_mem_rsp(rsp),
    .o_warm_restart(wrst)
  );
  nvj_mem_model i_mem (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_mem_req(req),
    .i_mem_cmd(cmd),
    .o_mem_rsp(rsp),
    .i_slow(slow),
    .i_files(files),
    .i_op_ok(op_ok)
  );
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ------
  // Command and restart log
  // ------
  always @(negedge i_clk)
  begin
    if (req === 1'b1)
      cmds.push_back(cmd);
    if (wrst === 1'b1)
      restarts++;
  end
  // ------
  // Shared tasks
  // ------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check8
  task automatic do_reset();
    i_sys_rst = 1'b1;
    cmds.delete();
    repeat (4) @(negedge i_clk);
    check8({7'h00, busy}, 8'h01);
    check8(param, Z);
    i_sys_rst = 1'b0;
  endtask : do_reset
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge i_clk);
      n++;
    end
    check8({7'h00, busy}, 8'h00);
  endtask : wait_idle
  task automatic write_job(input logic c, input logic [7:0] v,
                           input logic [7:0] exp);
    @(negedge i_clk);
    cmds.delete();
    restarts = 0;
    i_wr = '{1'b1, c, v};
    @(negedge i_clk);
    i_wr.valid = 1'b0;
    check8({7'h00, ack}, 8'h01);
    check8(code, exp);
  endtask : write_job
  task automatic check_seq(input logic [11:0] seq);
    int k;
    k = 0;
    for (int i = 0; i < 4; i++)
      if (seq[11-3*i -: 3] != 3'h0)
        k++;
    check8(8'(cmds.size()), 8'(k));
    for (int i = 0; i < k && i < cmds.size(); i++)
      check8({5'h00, cmds[i]}, {5'h00, seq[11-3*i -: 3]});
  endtask : check_seq
  task automatic run(input logic [7:0] v, input logic [3:0] f,
                     input logic [1:0] cok, input logic [7:0] mid,
                     input logic [7:0] fin, input logic [11:0] seq,
                     input int nrst);
    int n;
    files = f;
    {card, op_ok} = cok;
    repeat (3) @(negedge i_clk);
    write_job(1'b1, v, ACK);
    n = 0;
    while (param === v && n < 300)
    begin
      @(negedge i_clk);
      n++;
    end
    check8(n[7:0], 8'(`NVJ_ACK_CYCLES));
    check8(param, mid);
    wait_idle();
    check8(param, fin);
    check_seq(seq);
    check8(restarts[7:0], nrst[7:0]);
  endtask : run
  // ------
  // Scenarios
  // ------
  task automatic t_busy();
    write_job(1'b1, DL, ACK);
    write_job(1'b1, BK, `NVJ_REJ_STATE);
    check8(param, DL);
    wait_idle();
    check8(param, Z);
    $display("t_busy done");
  endtask : t_busy
  task automatic t_backup();
    wp = 1'b1;
    pulse = 1'b1;
    slow = 1'b1;
    run(BK, 4'h2, 2'h3, ACK, Z, {RN, WR, 6'h00}, 0);
    pulse = 1'b0;
    slow = 1'b0;
    run(BK, 4'h2, 2'h2, ACK, 8'h0D, {RN, WR, 6'h00}, 0);
    write_job(1'b1, 8'h00, ACK);
    check8(param, Z);
    run(BK, 4'h2, 2'h1, 8'h0B, 8'h0B, 12'h000, 0);
    full = 1'b1;
    run(BK, 4'h2, 2'h3, 8'h0C, 8'h0C, 12'h000, 0);
    full = 1'b0;
    $display("t_backup done");
  endtask : t_backup
  task automatic t_refuse();
    logic [19:0] tbl [7];
    logic [7:0] p;
    logic c;
    tbl = '{20'h801CC, 20'hB04CC, 20'h40414, 20'h60184, 20'h5026B,
            20'h5036B, 20'h4FF14};
    foreach (tbl[i])
    begin
      {wp, c, blk, pulse} = tbl[i][19:16];
      repeat (3) @(negedge i_clk);
      p = param;
      write_job(c, tbl[i][15:8], tbl[i][7:0]);
      @(negedge i_clk);
      check8(param, p);
      check8({7'h00, busy}, 8'h00);
    end
    {wp, blk, pulse} = 3'h0;
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_restore();
    run(RS, 4'h2, 2'h3, ACK, Z, {CP, CL, LP, 3'h0}, 1);
    slow = 1'b1;
    run(RS, 4'h8, 2'h3, ACK, Z, {CP, CF, CL, LF}, 1);
    run(RS, 4'h5, 2'h3, ACK, 8'h10, {CP, CF, 6'h00}, 0);
    slow = 1'b0;
    run(RS, 4'h1, 2'h3, ACK, 8'h0F, {CP, CF, 6'h00}, 0);
    run(RS, 4'h2, 2'h1, 8'h0E, 8'h0E, 12'h000, 0);
    run(RS, 4'h2, 2'h2, ACK, 8'h0F, {CP, CL, LP, 3'h0}, 1);
    $display("t_restore done");
  endtask : t_restore
  task automatic t_delete();
    run(DL, 4'h2, 2'h3, ACK, Z, {CL, 9'h000}, 1);
    run(DL, 4'h2, 2'h2, ACK, 8'h0A, {CL, 9'h000}, 1);
    $display("t_delete done");
  endtask : t_delete
  task automatic t_auto();
    repl = 1'b1;
    files = 4'h1;
    op_ok = 1'b1;
    do_reset();
    wait_idle();
    check_seq({CL, CP, CF, 3'h0});
    check8(param, Z);
    files = 4'h2;
    do_reset();
    wait_idle();
    check_seq({CL, CP, LP, 3'h0});
    check8(param, Z);
    repl = 1'b0;
    $display("t_auto done");
  endtask : t_auto
  task automatic print_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    #400000;
    num_errors++;
    $display("watchdog expired");
    print_verdict();
  end
  initial
  begin
    i_wr = '0;
    {wp, blk, pulse, full, repl, slow} = 6'h00;
    {card, op_ok} = 2'h3;
    files = 4'h2;
    i_sys_rst = 1'b1;
    @(negedge i_clk);
    do_reset();
    wait_idle();
    t_busy();
    t_backup();
    t_refuse();
    t_restore();
    t_delete();
    t_auto();
    print_verdict();
  end
endmodule : nvj_job_ctrl_bench

// ---- verification/nvj_mem_model.sv ----
// Memory engine model for the job controller bench
`timescale 1ns/100ps
module nvj_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Command side
  input wire logic i_mem_req,
  input wire nvj_pkg::nvj_cmd_t i_mem_cmd,
  output nvj_pkg::nvj_mem_rsp_t o_mem_rsp,
  // Behaviour chosen by the bench
  input wire logic i_slow,
  input wire logic [3:0] i_files,
  input wire logic i_op_ok
);
  logic pend;
  logic tgl;
  logic [7:0] cnt;
  nvj_pkg::nvj_cmd_t cmd;
  // ------
  // Command timing
  // ------
  always_ff @(posedge i_clk)
  begin
    tgl <= ~tgl & ~i_sys_rst;
    if (i_sys_rst || (pend && cnt == 8'h00))
      pend <= 1'b0;
    else if (i_mem_req)
    begin
      pend <= 1'b1;
      cmd <= i_mem_cmd;
      cnt <= i_slow ? 8'h14 : 8'h01;
    end
    else if (pend)
      cnt <= cnt - 8'h01;
  end
  // ------
  // Answer, junk outside done
  // ------
  always_comb
  begin
    o_mem_rsp = {1'b0, tgl, ~tgl};
    if (pend && cnt == 8'h00)
    begin
      case (cmd)
        nvj_pkg::MC_RENAME: o_mem_rsp = {1'b1, tgl, ~tgl};
        nvj_pkg::MC_CHK_PRI: o_mem_rsp = {1'b1, i_files[1:0]};
        nvj_pkg::MC_CHK_FB: o_mem_rsp = {1'b1, i_files[3:2]};
        default: o_mem_rsp = {1'b1, i_op_ok, 1'b0};
      endcase
    end
  end
endmodule : nvj_mem_model
